// ==== hw/hsp_fifo.sv ====
// Parameterised FIFO for the transmit path of the host serial port
`timescale 1ns/100ps
`default_nettype none
module hsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// Depth must be a power of two of at least two
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
		begin : g_bad
			$error("hsp_fifo: DEPTH must be a power of two, WIDTH positive");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic [AW:0] cnt_nxt;
	logic ready_r;
	logic valid_r;
	wire push = in_valid & ready_r;
	wire pop = out_ready & valid_r;

	////////////////////////////////////////////////////////////////////////
	// Occupancy and flags
	assign cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
	assign in_ready = ready_r;
	assign out_valid = valid_r;
	assign out_data = mem[rd_r];

	// Pointers and registered flags
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			ready_r <= 1'b1;
			valid_r <= 1'b0;
		end
		else
		begin
			wr_r <= wr_r + AW'(push);
			rd_r <= rd_r + AW'(pop);
			cnt_r <= cnt_nxt;
			ready_r <= cnt_nxt != (AW + 1)'(DEPTH);
			valid_r <= cnt_nxt != '0;
		end
	end

	// Storage write
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_r] <= in_data;
	end
endmodule
`default_nettype wire

// ==== hw/hsp_port.sv ====
// Host serial port: 8N1 UART with power-up packet and bit-rate startup
//
// Contract
// [RULE_01] Commands and responses travel as characters over an async UART.
// [RULE_02] Each frame is one start bit, eight data bits, no parity, one stop.
// [RULE_03] The rate is 9600 baud until another rate is selected and kept.
// [RULE_04] A set-rate command stores a new rate that the port retains. The code reloads saved_div_r with DEF_DIV on every rst.
// [RULE_05] After power-up the port runs at 9600 and stays there on an answer.
// [RULE_06] With no answer by the end of the wait the saved rate takes over.
// [RULE_07] On a four-wire link many drives are slaves of one master host.
// [RULE_08] The host originates commands and the drive executes each one.
// [RULE_09] The power-up packet 255, firmware, model goes out at 9600.
// [RULE_10] A carriage return of value 13 ends each command packet.
// [RULE_11] A 200 ms gap timer restarts per character and aborts the packet.
// [RULE_12] The wait for the answer to the power-up packet is a parameter.
`timescale 1ns/100ps
`default_nettype none
module hsp_port #(
	parameter int GAP_CYCLES = hsp_pkg::GAP_CYC,
	parameter int ACK_CYCLES = hsp_pkg::ACK_CYC,
	parameter int FIFO_DEPTH = hsp_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic rx_pin,
	output logic tx_pin,
	input wire logic [7:0] fw_version,
	input wire logic [7:0] model_no,
	input wire logic rate_load,
	input wire logic [15:0] rate_div,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_eop,
	output logic rx_abort,
	output logic frame_err,
	output logic boot_done,
	output logic saved_rate
);
	// Timer lengths must fit the timer width
	generate
		if (GAP_CYCLES < 1 || GAP_CYCLES >= (1 << hsp_pkg::TMR_W) ||
			ACK_CYCLES < 1 || ACK_CYCLES >= (1 << hsp_pkg::TMR_W))
		begin : g_bad_tmr
			$error("hsp_port: timer parameter out of range");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic rx_s1_r;
	logic rx_s2_r;
	hsp_pkg::hsp_line_e rx_st_r;
	logic [15:0] rx_cnt_r;
	logic [2:0] rx_bit_r;
	logic [7:0] rx_sh_r;
	hsp_pkg::hsp_line_e tx_st_r;
	logic [15:0] tx_cnt_r;
	logic [2:0] tx_bit_r;
	logic [7:0] tx_sh_r;
	logic tx_pin_r;
	hsp_pkg::hsp_boot_e boot_st_r;
	logic [1:0] boot_idx_r;
	logic [hsp_pkg::TMR_W-1:0] ack_cnt_r;
	logic [hsp_pkg::TMR_W-1:0] gap_cnt_r;
	logic pkt_open_r;
	logic [15:0] saved_div_r;
	logic [15:0] active_div_r;
	logic [7:0] rx_data_r;
	logic rx_valid_r;
	logic rx_eop_r;
	logic rx_abort_r;
	logic frame_err_r;
	logic saved_rate_r;
	logic boot_done_r;
	logic fifo_valid;
	logic [7:0] fifo_data;

	////////////////////////////////////////////////////////////////////////
	// Bit-time helper
	function automatic logic [15:0] reload(input logic [15:0] div);
		reload = div - 16'h0001;
	endfunction

	// Decode of line events
	wire rx_tick = rx_cnt_r == 16'h0000;
	wire tx_tick = tx_cnt_r == 16'h0000;
	wire rx_done = rx_st_r == hsp_pkg::HSP_STOP && rx_tick && rx_s2_r;
	wire rx_bad = rx_st_r == hsp_pkg::HSP_STOP && rx_tick && !rx_s2_r;
	wire rx_is_cr = rx_sh_r == hsp_pkg::CHAR_CR;
	wire tx_idle = tx_st_r == hsp_pkg::HSP_IDLE;
	wire boot_send = boot_st_r == hsp_pkg::HSP_B_SEND;
	wire boot_fin = boot_st_r == hsp_pkg::HSP_B_DONE;
	wire [7:0] boot_byte = boot_idx_r == 2'h0 ? hsp_pkg::PUP_MARK :
		boot_idx_r == 2'h1 ? fw_version : model_no;
	wire src_valid = boot_send | (boot_fin & fifo_valid); // [RULE_07]
	wire [7:0] src_data = boot_send ? boot_byte : fifo_data;
	wire tx_take = tx_idle & src_valid;
	wire fifo_pop = tx_idle & boot_fin;
	wire rate_ok = rate_div >= hsp_pkg::MIN_DIV;
	wire ack_out = ack_cnt_r == '0;

	////////////////////////////////////////////////////////////////////////
	// Transmit queue for response bytes
	hsp_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_txq (
		.clk(clk),
		.rst(rst),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchroniser on the receive pin
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
		end
		else
		begin
			rx_s1_r <= rx_pin;
			rx_s2_r <= rx_s1_r;
		end
	end

	// Receiver: mid-bit sampling of start, 8 data, stop
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_st_r <= hsp_pkg::HSP_IDLE;
			rx_cnt_r <= 16'h0000;
			rx_bit_r <= 3'h0;
			rx_sh_r <= 8'h00;
		end
		else
		begin
			rx_cnt_r <= rx_tick ? reload(active_div_r) : rx_cnt_r - 16'h0001;
			case (rx_st_r)
				hsp_pkg::HSP_IDLE:
				begin
					rx_cnt_r <= active_div_r >> 1;
					if (!rx_s2_r)
						rx_st_r <= hsp_pkg::HSP_START; // [RULE_02]
				end
				hsp_pkg::HSP_START:
				begin
					rx_bit_r <= 3'h0;
					if (rx_tick)
						rx_st_r <= rx_s2_r ? hsp_pkg::HSP_IDLE :
							hsp_pkg::HSP_DATA;
				end
				hsp_pkg::HSP_DATA:
				begin
					if (rx_tick)
					begin
						rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]}; // [RULE_02]
						rx_bit_r <= rx_bit_r + 3'h1;
						if (rx_bit_r == 3'h7)
							rx_st_r <= hsp_pkg::HSP_STOP; // [RULE_02]
					end
				end
				hsp_pkg::HSP_STOP:
				begin
					if (rx_tick)
						rx_st_r <= hsp_pkg::HSP_IDLE;
				end
				default:
					rx_st_r <= hsp_pkg::HSP_IDLE;
			endcase
		end
	end

	// Received byte, end-of-packet and framing pulses
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_data_r <= 8'h00;
			rx_valid_r <= 1'b0;
			rx_eop_r <= 1'b0;
			frame_err_r <= 1'b0;
		end
		else
		begin
			if (rx_done)
				rx_data_r <= rx_sh_r; // [RULE_01] [RULE_08]
			rx_valid_r <= rx_done;
			rx_eop_r <= rx_done & rx_is_cr; // [RULE_10]
			frame_err_r <= rx_bad;
		end
	end

	// Inter-character gap timer, restarted per byte
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			gap_cnt_r <= '0;
			pkt_open_r <= 1'b0;
			rx_abort_r <= 1'b0;
		end
		else
		begin
			rx_abort_r <= 1'b0;
			if (rx_done)
			begin
				gap_cnt_r <= hsp_pkg::TMR_W'(GAP_CYCLES - 1); // [RULE_11]
				pkt_open_r <= !rx_is_cr; // [RULE_10]
			end
			else if (pkt_open_r)
			begin
				gap_cnt_r <= gap_cnt_r - hsp_pkg::TMR_W'(1);
				if (gap_cnt_r == '0)
				begin
					pkt_open_r <= 1'b0;
					rx_abort_r <= 1'b1; // [RULE_11]
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmitter: start, 8 data LSB first, stop
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tx_st_r <= hsp_pkg::HSP_IDLE;
			tx_cnt_r <= 16'h0000;
			tx_bit_r <= 3'h0;
			tx_sh_r <= 8'h00;
			tx_pin_r <= 1'b1;
		end
		else
		begin
			tx_cnt_r <= tx_tick ? reload(active_div_r) : tx_cnt_r - 16'h0001;
			case (tx_st_r)
				hsp_pkg::HSP_IDLE:
				begin
					tx_cnt_r <= reload(active_div_r);
					if (tx_take)
					begin
						tx_sh_r <= src_data;
						tx_pin_r <= 1'b0; // [RULE_02]
						tx_st_r <= hsp_pkg::HSP_START;
					end
				end
				hsp_pkg::HSP_START:
				begin
					tx_bit_r <= 3'h0;
					if (tx_tick)
					begin
						tx_pin_r <= tx_sh_r[0];
						tx_st_r <= hsp_pkg::HSP_DATA;
					end
				end
				hsp_pkg::HSP_DATA:
				begin
					if (tx_tick)
					begin
						tx_sh_r <= tx_sh_r >> 1;
						tx_bit_r <= tx_bit_r + 3'h1;
						tx_pin_r <= tx_bit_r == 3'h7 ? 1'b1 : tx_sh_r[1];
						if (tx_bit_r == 3'h7)
							tx_st_r <= hsp_pkg::HSP_STOP; // [RULE_02]
					end
				end
				hsp_pkg::HSP_STOP:
				begin
					if (tx_tick)
						tx_st_r <= hsp_pkg::HSP_IDLE;
				end
				default:
					tx_st_r <= hsp_pkg::HSP_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Retained rate chosen by the set-rate commands
	always_ff @(posedge clk)
	begin
		if (rst)
			saved_div_r <= hsp_pkg::DEF_DIV; // [RULE_03]
		else if (rate_load && rate_ok)
			saved_div_r <= rate_div; // [RULE_04]
	end

	// Power-up packet, answer wait and rate switch
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			boot_st_r <= hsp_pkg::HSP_B_SEND;
			boot_idx_r <= 2'h0;
			ack_cnt_r <= '0;
			active_div_r <= hsp_pkg::DEF_DIV; // [RULE_05] [RULE_09]
			saved_rate_r <= 1'b0;
			boot_done_r <= 1'b0;
		end
		else
		begin
			case (boot_st_r)
				hsp_pkg::HSP_B_SEND:
				begin
					ack_cnt_r <= hsp_pkg::TMR_W'(ACK_CYCLES - 1); // [RULE_12]
					if (tx_take)
					begin
						boot_idx_r <= boot_idx_r + 2'h1; // [RULE_09]
						if (boot_idx_r == hsp_pkg::PUP_LAST)
							boot_st_r <= hsp_pkg::HSP_B_WAIT;
					end
				end
				hsp_pkg::HSP_B_WAIT:
				begin
					if (!ack_out)
						ack_cnt_r <= ack_cnt_r - hsp_pkg::TMR_W'(1);
					if (rx_done)
					begin
						boot_st_r <= hsp_pkg::HSP_B_DONE; // [RULE_05]
						boot_done_r <= 1'b1;
					end
					else if (ack_out && tx_idle)
					begin
						boot_st_r <= hsp_pkg::HSP_B_DONE;
						active_div_r <= saved_div_r; // [RULE_06]
						saved_rate_r <= 1'b1;
						boot_done_r <= 1'b1;
					end
				end
				hsp_pkg::HSP_B_DONE:
					boot_st_r <= hsp_pkg::HSP_B_DONE;
				default:
				begin
					boot_st_r <= hsp_pkg::HSP_B_DONE;
					boot_done_r <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign tx_pin = tx_pin_r;
	assign rx_data = rx_data_r;
	assign rx_valid = rx_valid_r;
	assign rx_eop = rx_eop_r;
	assign rx_abort = rx_abort_r;
	assign frame_err = frame_err_r;
	assign boot_done = boot_done_r;
	assign saved_rate = saved_rate_r;
endmodule
`default_nettype wire

// ==== inc/hsp_pkg.sv ====
// Shared constants and state types of the host serial port
`default_nettype none
package hsp_pkg;
	// Device clock
	localparam int CLK_HZ = 10_000_000;
	// Frame format: start, data, parity, stop bits
	localparam int START_BITS = 1;
	localparam int DATA_BITS = 8;
	localparam int PARITY_BITS = 0;
	localparam int STOP_BITS = 1;
	// Factory bit rate and its divisor, rounded to nearest clock
	localparam int DEF_BAUD = 9600;
	localparam int DIV_W = 16;
	localparam logic [15:0] DEF_DIV = 16'((CLK_HZ + DEF_BAUD / 2) / DEF_BAUD);
	// Smallest divisor the bit timing can serve
	localparam logic [15:0] MIN_DIV = 16'h0004;
	// Packet framing characters
	localparam logic [7:0] PUP_MARK = 8'hFF;
	localparam logic [7:0] CHAR_CR = 8'h0D;
	localparam logic [1:0] PUP_LAST = 2'h2;
	// Inter-character gap timeout
	localparam int GAP_MS = 200;
	localparam int GAP_CYC = CLK_HZ / 1000 * GAP_MS;
	// Wait for the host's answer to the power-up packet
	localparam int ACK_MS = 100;
	localparam int ACK_CYC = CLK_HZ / 1000 * ACK_MS;
	// Width of the long timers
	localparam int TMR_W = 24;
	// Transmit queue
	localparam int FIFO_DEPTH = 16;
	// Serial engine states
	typedef enum logic [1:0]
	{
		HSP_IDLE = 2'b00,
		HSP_START = 2'b01,
		HSP_DATA = 2'b10,
		HSP_STOP = 2'b11
	} hsp_line_e;
	// Power-up sequence states
	typedef enum logic [1:0]
	{
		HSP_B_SEND = 2'b00,
		HSP_B_WAIT = 2'b01,
		HSP_B_DONE = 2'b10
	} hsp_boot_e;
endpackage
`default_nettype wire

// ==== sim/hsp_host_model.sv ====
// Host serial port model: sends and collects 8N1 characters
`timescale 1ns/100ps
`default_nettype none
module hsp_host_model (
	input wire logic clk,
	input wire logic tx_pin,
	input wire logic [15:0] bit_div,
	output logic rx_pin
);
	logic [7:0] got[$];
	initial rx_pin = 1'b1;
	// One frame back to back, start low, LSB first, chosen stop level
	task automatic send_byte(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk);
			rx_pin <= f[i];
			repeat (bit_div - 1) @(posedge clk);
		end
		@(posedge clk);
		rx_pin <= 1'b1;
	endtask
	// Collect frames mid-bit, drop those with a low stop bit
	initial forever
	begin
		logic [7:0] b;
		int d;
		@(negedge tx_pin);
		#1 d = bit_div;
		repeat (d / 2) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (d) @(posedge clk);
			b[i] = tx_pin;
		end
		repeat (d) @(posedge clk);
		if (tx_pin === 1'b1)
			got.push_back(b);
	end
endmodule
`default_nettype wire

// ==== sim/hsp_port_asserts.sv ====
// Concurrent checks on the host serial port pins
`timescale 1ns/100ps
`default_nettype none
module hsp_port_chk #(
	parameter int GAP_CYCLES = 20,
	parameter int ACK_CYCLES = 20,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_pin,
	input wire logic tx_ready,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic rx_eop,
	input wire logic rx_abort,
	input wire logic frame_err,
	input wire logic boot_done,
	input wire logic saved_rate
);
	localparam int D = int'(hsp_pkg::DEF_DIV);
	localparam int BOOT_MIN = 20 * D + ACK_CYCLES;
	// An answer may end the wait as soon as the third byte is loaded
	localparam int ANS_MIN = 20 * D;
	localparam int BOOT_MAX = 30 * D + ACK_CYCLES + 300;
	int boot_cnt;
	int gap_cnt;
	// Cycles since reset release and since the last byte
	always_ff @(posedge clk)
	begin
		boot_cnt <= rst ? 0 : boot_cnt + 1;
		gap_cnt <= rx_valid ? 1 : gap_cnt + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Start bit of the power-up mark
	sequence s_start;
		!tx_pin [*8];
	endsequence
	sequence s_rst_out;
		tx_pin && tx_ready && !rx_valid && !boot_done && !saved_rate;
	endsequence
	a_reset_out: assert property ($fell(rst) |-> s_rst_out)
		else $error("outputs wrong at reset release");
	a_boot_start: assert property ($fell(rst) |=> s_start)
		else $error("power-up mark did not start");
	a_eop_cr: assert property (
		rx_valid |-> rx_eop == (rx_data == hsp_pkg::CHAR_CR))
		else $error("end of packet flag wrong");
	a_eop_alone: assert property (rx_eop |-> rx_valid)
		else $error("end of packet without byte");
	a_valid_pulse: assert property (
		rx_valid |=> !rx_valid && !frame_err)
		else $error("receive pulse too long");
	a_ferr_drop: assert property (frame_err |-> !rx_valid)
		else $error("bad frame delivered");
	a_abort_gap: assert property (
		rx_abort |-> gap_cnt == GAP_CYCLES && !rx_valid)
		else $error("abort at wrong time");
	a_boot_hold: assert property (
		boot_done |=> boot_done && $stable(saved_rate))
		else $error("startup state changed");
	a_saved_boot: assert property (saved_rate |-> boot_done)
		else $error("saved rate before startup end");
	a_boot_min: assert property (
		$rose(boot_done) |-> boot_cnt >= (saved_rate ? BOOT_MIN : ANS_MIN))
		else $error("startup wait too short");
	a_boot_max: assert property (boot_cnt == BOOT_MAX |-> boot_done)
		else $error("startup wait too long");
endmodule
bind hsp_port hsp_port_chk #(
	.GAP_CYCLES(GAP_CYCLES),
	.ACK_CYCLES(ACK_CYCLES),
	.FIFO_DEPTH(FIFO_DEPTH)
) u_chk (
	.clk(clk),
	.rst(rst),
	.tx_pin(tx_pin),
	.tx_ready(tx_ready),
	.rx_data(rx_data),
	.rx_valid(rx_valid),
	.rx_eop(rx_eop),
	.rx_abort(rx_abort),
	.frame_err(frame_err),
	.boot_done(boot_done),
	.saved_rate(saved_rate)
);
`default_nettype wire

// ==== sim/hsp_port_tb.sv ====
// Self-checking bench for the host serial port
`timescale 1ns/100ps
`default_nettype none
module hsp_port_tb;
	localparam logic [15:0] SAVED_DIV = 16'h0008;
	logic clk, rst, rx_pin, tx_pin, rate_load, tx_valid, tx_ready;
	logic rx_valid, rx_eop, rx_abort, frame_err, boot_done, saved_rate;
	logic [7:0] fw_version, model_no, tx_data, rx_data, b, e;
	logic [15:0] rate_div;
	wire logic [15:0] host_div;
	logic [7:0] exp_rx[$], exp_tx[$];
	int n_fail = 0, cmp_count = 0, n_abort = 0, n_ferr = 0, n_acc = 0;
	hsp_port #(.GAP_CYCLES(2000), .ACK_CYCLES(14000)) DUT (
		.clk(clk),
		.rst(rst),
		.rx_pin(rx_pin),
		.tx_pin(tx_pin),
		.fw_version(fw_version),
		.model_no(model_no),
		.rate_load(rate_load),
		.rate_div(rate_div),
		.tx_valid(tx_valid),
		.tx_data(tx_data),
		.tx_ready(tx_ready),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.rx_eop(rx_eop),
		.rx_abort(rx_abort),
		.frame_err(frame_err),
		.boot_done(boot_done),
		.saved_rate(saved_rate)
	);
	// Host decodes at the rate the port is running
	assign host_div = saved_rate ? SAVED_DIV : hsp_pkg::DEF_DIV;
	hsp_host_model host (
		.clk(clk),
		.tx_pin(tx_pin),
		.bit_div(host_div),
		.rx_pin(rx_pin)
	);
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic give_up(input string what);
		n_fail++;
		$display("unexpected %s: expected done seen timeout", what);
		report_and_stop;
	endtask
	task automatic expect_tx(input string what, input logic [7:0] x,
		input int lim);
		int i;
		for (i = 0; i < lim && host.got.size() == 0; i++)
			@(negedge clk);
		if (i == lim)
			give_up(what);
		else
			check(what, {8'h00, host.got.pop_front()}, {8'h00, x});
	endtask
	task automatic wait_boot(input int lim);
		int i;
		for (i = 0; i < lim && boot_done !== 1'b1; i++)
			@(negedge clk);
		if (i == lim)
			give_up("boot_done");
	endtask
	// Reference receive path: byte order, end flag, pulse counts
	always @(posedge clk)
	begin
		if (rx_valid === 1'b1)
		begin
			e = exp_rx.size() > 0 ? exp_rx.pop_front() : 8'hXX;
			check("rx_data", {8'h00, rx_data}, {8'h00, e});
			check("rx_eop", 16'(rx_eop), 16'(e == 8'h0D));
		end
		n_abort += rx_abort === 1'b1;
		n_ferr += frame_err === 1'b1;
	end
	initial
	begin
		void'($urandom(10));
		{rst, rate_load, tx_valid, rate_div, tx_data} = {3'b100, 24'h0};
		fw_version = 8'($urandom);
		model_no = 8'($urandom);
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// Fill the queue while the power-up packet goes out
		tx_valid <= 1'b1;
		tx_data <= 8'($urandom);
		repeat (20)
		begin
			@(posedge clk);
			if (tx_ready === 1'b1)
			begin
				exp_tx.push_back(tx_data);
				n_acc++;
				tx_data <= 8'($urandom);
			end
		end
		tx_valid <= 1'b0;
		rate_div <= SAVED_DIV;
		rate_load <= 1'b1;
		@(posedge clk);
		rate_div <= 16'h0003;
		@(posedge clk);
		rate_load <= 1'b0;
		check("accepted", 16'(n_acc), 16'h0010);
		expect_tx("mark", 8'hFF, 12000);
		expect_tx("firmware", fw_version, 12000);
		expect_tx("model", model_no, 12000);
		wait_boot(20000);
		check("saved_rate", 16'(saved_rate), 16'h0001);
		while (exp_tx.size() > 0)
			expect_tx("queued", exp_tx.pop_front(), 200);
		$display("test boot without answer done");
		// Packet at the saved rate, then a stalled one and a bad frame
		repeat (4)
		begin
			b = 8'($urandom);
			b = b == 8'h0D ? 8'h0E : b;
			exp_rx.push_back(b);
			host.send_byte(b, 1'b1);
		end
		exp_rx.push_back(8'h0D);
		host.send_byte(8'h0D, 1'b1);
		repeat (2100) @(posedge clk);
		check("abort after cr", 16'(n_abort), 16'h0000);
		exp_rx.push_back(8'h41);
		host.send_byte(8'h41, 1'b1);
		repeat (2100) @(posedge clk);
		check("abort", 16'(n_abort), 16'h0001);
		host.send_byte(8'h55, 1'b0);
		repeat (20) @(posedge clk);
		check("frame_err", 16'(n_ferr), 16'h0001);
		$display("test receive done");
		// Second power-up with a host that answers the packet
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		expect_tx("mark", 8'hFF, 12000);
		expect_tx("firmware", fw_version, 12000);
		repeat (600) @(posedge clk);
		exp_rx.push_back(8'hA5);
		host.send_byte(8'hA5, 1'b1);
		expect_tx("model", model_no, 12000);
		wait_boot(8000);
		check("saved_rate", 16'(saved_rate), 16'h0000);
		tx_valid <= 1'b1;
		tx_data <= 8'h3C;
		@(posedge clk);
		tx_valid <= 1'b0;
		expect_tx("reply", 8'h3C, 12000);
		$display("test boot with answer done");
		report_and_stop;
	end
endmodule
`default_nettype wire
